// file: asr_top.sv
`timescale 1ns/1ns
// Summary of operation
// RULE_01 - tx flag high when enabled, buffer empty
// RULE_02 - tx flag updates two cycles after write
// RULE_03 - tx flag is read-only to software
// RULE_04 - flag independent of enable; enable gates request
// RULE_05 - software enables tx interrupt only while sending
// RULE_06 - software loads divisor and speed bits first
// RULE_07 - software sets port enable, async, then receive
// RULE_08 - nine data bits when ninth enable set
// RULE_09 - ready flag on buffer load; request if enabled
// RULE_10 - rx request needs rx, global, peripheral enables
// RULE_11 - status holds errors and ninth bit; read first
// RULE_12 - buffer read returns low byte and pops
// RULE_13 - overrun set when character completes, buffer full
// RULE_14 - clearing receive enable clears overrun
// RULE_15 - address mode accepts only ninth-bit-set characters; code filters only when nine-bit mode is set
// RULE_16 - accepted address characters report ninth bit one
// RULE_17 - software clears address mode once addressed
// RULE_18 - start low, data, stop high, idle high
// RULE_19 - lsb first, shared format and rate
// RULE_20 - queued character waits for previous stop bit
// RULE_21 - two-entry receive queue, status paired per entry
// RULE_22 - start on falling edge, sample mid-bit
module asr_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial line
	input wire logic rx_pin,
	output logic tx_pin,
	// interrupt requests
	output logic tx_int_req,
	output logic rx_int_req
);

	asr_pkg::asr_state_t s_q, s_d;

	// hclk cycles per bit time for the selected divisor and prescale
	function automatic logic [asr_pkg::CNT_W-1:0] bit_cycles(input logic [15:0] div,
			input logic high, input logic wide);
		logic [asr_pkg::CNT_W-1:0] n;
		n = wide ? {8'h00, div} + 24'h00_0001 : {16'h0000, div[7:0]} + 24'h00_0001;
		if (wide && high) begin
			bit_cycles = n << 2;
		end else if (wide || high) begin
			bit_cycles = n << 4;
		end else begin
			bit_cycles = n << 6;
		end
	endfunction

	logic tx_on, rx_on, nine, addr_phase, rd_rx, wr_tx, tx_done, tx_load, push, accept;
	logic [asr_pkg::CNT_W-1:0] per;
	logic [10:0] frame;
	logic [8:0] rx_word;
	asr_pkg::asr_rx_entry_t head, ent;

	always_comb begin
		s_d = s_q;
		tx_on = s_q.ctrl[asr_pkg::CTL_PORT_EN] && !s_q.ctrl[asr_pkg::CTL_CLKMODE]
			&& s_q.ctrl[asr_pkg::CTL_TXEN];
		rx_on = s_q.ctrl[asr_pkg::CTL_PORT_EN] && !s_q.ctrl[asr_pkg::CTL_CLKMODE]
			&& s_q.ctrl[asr_pkg::CTL_RX_EN];
		nine = s_q.ctrl[asr_pkg::CTL_NINE]; // RULE_19
		per = bit_cycles(s_q.baud, s_q.ctrl[asr_pkg::CTL_BHIGH], s_q.ctrl[asr_pkg::CTL_BWIDE]);
		head = s_q.fifo[s_q.rd_ptr];
		addr_phase = hsel && hready && htrans[1];
		rd_rx = addr_phase && !hwrite && haddr[7:0] == asr_pkg::OFS_RXBUF;
		wr_tx = s_q.wr_pend && s_q.waddr == asr_pkg::OFS_TXBUF && tx_on;
		tx_done = s_q.tx_busy && s_q.tx_cnt == '0 && s_q.tx_left == '0;
		tx_load = s_q.txbuf_v && (!s_q.tx_busy || tx_done) && tx_on; // RULE_20
		push = 1'b0;
		accept = 1'b0;
		rx_word = '0;
		ent = '0;
		frame = '0;

		// bus: registered answer, zero wait states, always okay
		s_d.hready = 1'b1;
		s_d.hresp = 1'b0;
		s_d.wr_pend = addr_phase && hwrite;
		if (addr_phase && hwrite) begin
			s_d.waddr = haddr[7:0];
		end
		if (addr_phase && !hwrite) begin
			case (haddr[7:0])
				asr_pkg::OFS_CTRL: s_d.hrdata = {24'h00_0000, s_q.ctrl};
				asr_pkg::OFS_BAUD: s_d.hrdata = {16'h0000, s_q.baud};
				asr_pkg::OFS_IEN: s_d.hrdata = {28'h000_0000, s_q.ien};
				asr_pkg::OFS_STAT: begin
					s_d.hrdata = '0;
					s_d.hrdata[asr_pkg::STA_TXFLAG] = s_q.flag_pipe[asr_pkg::TXFLAG_DELAY-1];
					s_d.hrdata[asr_pkg::STA_RXRDY] = s_q.count != 2'b00;
					s_d.hrdata[asr_pkg::STA_OVR] = s_q.ovr;
					s_d.hrdata[asr_pkg::STA_FERR] = s_q.count != 2'b00 && head.ferr; // RULE_11
					s_d.hrdata[asr_pkg::STA_NINTH] = s_q.count != 2'b00 && head.ninth; // RULE_11
					s_d.hrdata[asr_pkg::STA_TXBUSY] = s_q.tx_busy;
				end
				asr_pkg::OFS_RXBUF: s_d.hrdata = {24'h00_0000, head.data}; // RULE_12
				default: s_d.hrdata = '0;
			endcase
		end
		// status register writes are dropped: the tx flag has no write path
		if (s_q.wr_pend) begin
			case (s_q.waddr)
				asr_pkg::OFS_CTRL: s_d.ctrl = hwdata[asr_pkg::CTL_W-1:0];
				asr_pkg::OFS_BAUD: s_d.baud = hwdata[15:0];
				asr_pkg::OFS_IEN: s_d.ien = hwdata[asr_pkg::IEN_W-1:0];
				default: s_d.ctrl = s_q.ctrl; // RULE_03
			endcase
		end

		// transmitter
		if (wr_tx) begin
			s_d.txbuf = hwdata[8:0];
			s_d.txbuf_v = 1'b1;
		end
		if (s_q.tx_busy && s_q.tx_cnt != '0) begin
			s_d.tx_cnt = s_q.tx_cnt - 24'h00_0001;
		end else if (s_q.tx_busy && !tx_done) begin
			s_d.tx_pin = s_q.tx_sh[0]; // RULE_19
			s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
			s_d.tx_left = s_q.tx_left - 4'h1;
			s_d.tx_cnt = per - 24'h00_0001;
		end
		if (tx_done) begin
			s_d.tx_busy = 1'b0;
			s_d.tx_pin = 1'b1;
		end
		if (tx_load) begin
			// start bit goes out now; the rest waits in the shifter
			frame = nine ? {1'b1, s_q.txbuf, 1'b0} : {2'b11, s_q.txbuf[7:0], 1'b0};
			s_d.tx_sh = {1'b1, frame[10:1]};
			s_d.tx_left = (nine ? asr_pkg::FRAME9_BITS : asr_pkg::FRAME8_BITS) - 4'h1;
			s_d.tx_cnt = per - 24'h00_0001;
			s_d.tx_pin = 1'b0; // RULE_18
			s_d.tx_busy = 1'b1;
			s_d.txbuf_v = wr_tx;
		end
		if (!tx_on) begin
			s_d.txbuf_v = 1'b0;
			s_d.tx_busy = 1'b0;
			s_d.tx_pin = 1'b1; // RULE_18
		end
		// flag delayed so a poll right after the write sees the old state
		s_d.flag_pipe = {s_q.flag_pipe[0], tx_on && !s_d.txbuf_v}; // RULE_01 RULE_02
		s_d.tx_irq = s_q.flag_pipe[asr_pkg::TXFLAG_DELAY-1] && s_q.ien[asr_pkg::IEN_TX]; // RULE_04

		// receiver; only rx_sync[1] and rx_sync[2] feed logic
		s_d.rx_sync = {s_q.rx_sync[1:0], rx_pin};
		if (s_q.rx_cnt != '0) begin
			s_d.rx_cnt = s_q.rx_cnt - 24'h00_0001;
		end
		case (s_q.rx_st)
			asr_pkg::RX_IDLE: begin
				if (rx_on && !s_q.ovr && s_q.rx_sync[2] && !s_q.rx_sync[1]) begin
					s_d.rx_st = asr_pkg::RX_START; // RULE_22
					s_d.rx_cnt = (per >> 1) - 24'h00_0001;
				end
			end
			asr_pkg::RX_START: begin
				if (s_q.rx_cnt == '0) begin
					s_d.rx_st = s_q.rx_sync[1] ? asr_pkg::RX_IDLE : asr_pkg::RX_DATA;
					s_d.rx_cnt = per - 24'h00_0001;
					s_d.rx_bits = '0;
				end
			end
			asr_pkg::RX_DATA: begin
				if (s_q.rx_cnt == '0) begin
					s_d.rx_sh = {s_q.rx_sync[1], s_q.rx_sh[8:1]}; // RULE_19 RULE_22
					s_d.rx_bits = s_q.rx_bits + 4'h1;
					s_d.rx_cnt = per - 24'h00_0001;
					if (s_q.rx_bits == (nine ? asr_pkg::DATA9_BITS : asr_pkg::DATA8_BITS) - 4'h1) begin
						s_d.rx_st = asr_pkg::RX_STOP; // RULE_08
					end
				end
			end
			asr_pkg::RX_STOP: begin
				if (s_q.rx_cnt == '0) begin
					rx_word = nine ? s_q.rx_sh : {1'b0, s_q.rx_sh[8:1]};
					ent.ferr = !s_q.rx_sync[1]; // RULE_18
					ent.ninth = rx_word[8]; // RULE_16
					ent.data = rx_word[7:0];
					accept = !(s_q.ctrl[asr_pkg::CTL_ADDR_DET] && nine && !rx_word[8]); // RULE_15 RULE_17
					push = accept;
					s_d.rx_st = asr_pkg::RX_IDLE;
				end
			end
			default: s_d.rx_st = asr_pkg::RX_IDLE;
		endcase
		if (!rx_on) begin
			s_d.rx_st = asr_pkg::RX_IDLE;
		end

		// two-entry queue; pop before push so a read frees room at once
		if (rd_rx && s_q.count != 2'b00) begin
			s_d.rd_ptr = !s_q.rd_ptr; // RULE_12
			s_d.count = s_q.count - 2'b01;
		end
		if (push) begin
			if (s_d.count == 2'b10) begin
				s_d.ovr = 1'b1; // RULE_13
			end else begin
				s_d.fifo[s_d.rd_ptr ^ s_d.count[0]] = ent; // RULE_21
				s_d.count = s_d.count + 2'b01; // RULE_09
			end
		end
		if (!s_q.ctrl[asr_pkg::CTL_RX_EN]) begin
			s_d.ovr = 1'b0; // RULE_14
		end
		s_d.rx_irq = s_d.count != 2'b00 && s_q.ien[asr_pkg::IEN_RX]
			&& s_q.ien[asr_pkg::IEN_GLOBAL] && s_q.ien[asr_pkg::IEN_PERIPH]; // RULE_09 RULE_10
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.ctrl <= asr_pkg::CTRL_RST;
			s_q.baud <= asr_pkg::BAUD_RST;
			s_q.ien <= asr_pkg::IEN_RST;
			s_q.hready <= 1'b1;
			s_q.tx_pin <= 1'b1;
			s_q.rx_sync <= 3'b111;
			s_q.rx_st <= asr_pkg::RX_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.hrdata;
	assign hreadyout = s_q.hready;
	assign hresp = s_q.hresp;
	assign tx_pin = s_q.tx_pin;
	assign tx_int_req = s_q.tx_irq;
	assign rx_int_req = s_q.rx_irq;

	// checks
	tx_flag_delay_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
		(tx_on && s_q.flag_pipe == 2'b11 && wr_tx && s_q.tx_busy && !tx_done && !s_q.txbuf_v)
		|=> s_q.flag_pipe[1] ##1 !s_q.flag_pipe[1])
		else $error("tx flag did not settle two cycles after write");
	tx_flag_state_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
		s_q.txbuf_v && tx_on ##1 s_q.txbuf_v && tx_on ##1 s_q.txbuf_v && tx_on
		|-> !s_q.flag_pipe[1])
		else $error("tx flag high while a character waits");
	tx_irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
		s_q.tx_irq |-> $past(s_q.ien[asr_pkg::IEN_TX]) && $past(s_q.flag_pipe[1]))
		else $error("tx request without flag and enable");
	rx_irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
		s_q.rx_irq |-> $past(s_q.ien) == 4'hF || $past(s_q.ien[3:1]) == 3'h7)
		else $error("rx request with an enable clear");
	rx_ready_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
		push && s_q.count == 2'b00 |=> s_q.count == 2'b01)
		else $error("accepted character did not raise ready");
	ovr_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_13
		push && s_q.count == 2'b10 && !rd_rx && s_q.ctrl[asr_pkg::CTL_RX_EN] |=> s_q.ovr)
		else $error("overrun not flagged on full queue");
	ovr_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_14
		!s_q.ctrl[asr_pkg::CTL_RX_EN] |=> !s_q.ovr)
		else $error("overrun survived receive disable");
	addr_filter_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_15
		push && s_q.ctrl[asr_pkg::CTL_ADDR_DET] && nine |-> ent.ninth)
		else $error("address mode accepted data character");
	queue_depth_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_21
		s_q.count != 2'b11)
		else $error("receive queue above two entries");
	tx_start_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18 RULE_20
		tx_load |=> !tx_pin && s_q.tx_busy)
		else $error("start bit missing after load");
	tx_flag_idle_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
		tx_on && !s_q.txbuf_v ##1 tx_on && !s_q.txbuf_v ##1 tx_on && !s_q.txbuf_v
		|-> s_q.flag_pipe[1])
		else $error("tx flag low with nothing waiting");
	// receive queue and status
	ninth_bit_report_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_16
		push && s_q.ctrl[asr_pkg::CTL_ADDR_DET] && nine && s_q.count == 2'b00
		|=> head.ninth)
		else $error("accepted address character lost its ninth bit");
	rx_pop_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
		rd_rx && s_q.count != 2'b00 && !push |=> s_q.count == $past(s_q.count) - 2'b01)
		else $error("buffer read did not remove a character");
	rxbuf_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
		rd_rx |=> hrdata == {24'h00_0000, $past(head.data)})
		else $error("buffer read returned wrong byte");
	empty_status_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
		addr_phase && !hwrite && haddr[7:0] == asr_pkg::OFS_STAT && s_q.count == 2'b00
		|=> !hrdata[asr_pkg::STA_FERR] && !hrdata[asr_pkg::STA_NINTH])
		else $error("status shows character bits with queue empty");
	tx_load_cv: cover property (@(posedge hclk) disable iff (!hresetn) tx_load && s_q.tx_busy);
	ovr_cv: cover property (@(posedge hclk) disable iff (!hresetn) !s_q.ovr ##1 s_q.ovr);
	addr_drop_cv: cover property (@(posedge hclk) disable iff (!hresetn)
		s_q.rx_st == asr_pkg::RX_STOP && s_q.rx_cnt == '0 && !accept);
	rx_pop_cv: cover property (@(posedge hclk) disable iff (!hresetn)
		rd_rx && s_q.count == 2'b10);

endmodule // asr_top

// file: asr_pkg.sv
package asr_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BAUD = 8'h04;
	localparam logic [7:0] OFS_IEN = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_TXBUF = 8'h10;
	localparam logic [7:0] OFS_RXBUF = 8'h14;

	// control register fields
	localparam int CTL_PORT_EN = 0;
	localparam int CTL_CLKMODE = 1;
	localparam int CTL_RX_EN = 2;
	localparam int CTL_NINE = 3;
	localparam int CTL_ADDR_DET = 4;
	localparam int CTL_TXEN = 5;
	localparam int CTL_BHIGH = 6;
	localparam int CTL_BWIDE = 7;
	localparam int CTL_W = 8;

	// interrupt enable fields
	localparam int IEN_TX = 0;
	localparam int IEN_RX = 1;
	localparam int IEN_GLOBAL = 2;
	localparam int IEN_PERIPH = 3;
	localparam int IEN_W = 4;

	// status register fields
	localparam int STA_TXFLAG = 0;
	localparam int STA_RXRDY = 1;
	localparam int STA_OVR = 2;
	localparam int STA_FERR = 3;
	localparam int STA_NINTH = 4;
	localparam int STA_TXBUSY = 5;

	// reset values
	localparam logic [CTL_W-1:0] CTRL_RST = 8'h00;
	localparam logic [15:0] BAUD_RST = 16'h0000;
	localparam logic [IEN_W-1:0] IEN_RST = 4'h0;

	// frame lengths in bit times, start and stop included; then data bit counts
	localparam logic [3:0] FRAME8_BITS = 4'hA;
	localparam logic [3:0] FRAME9_BITS = 4'hB;
	localparam logic [3:0] DATA8_BITS = 4'h8;
	localparam logic [3:0] DATA9_BITS = 4'h9;
	// delay of the tx flag after a buffer write, in cycles
	localparam int TXFLAG_DELAY = 2;
	localparam int CNT_W = 24;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11,
		RX_STOP = 2'b10
	} asr_rx_state_t;

	// one received character: framing error, ninth bit, low byte
	typedef struct packed {
		logic ferr;
		logic ninth;
		logic [7:0] data;
	} asr_rx_entry_t;

	typedef struct packed {
		logic [CTL_W-1:0] ctrl;
		logic [15:0] baud;
		logic [IEN_W-1:0] ien;
		logic wr_pend;
		logic [7:0] waddr;
		logic [31:0] hrdata;
		logic hready;
		logic hresp;
		logic [8:0] txbuf;
		logic txbuf_v;
		logic tx_busy;
		logic [10:0] tx_sh;
		logic [3:0] tx_left;
		logic [CNT_W-1:0] tx_cnt;
		logic tx_pin;
		logic [TXFLAG_DELAY-1:0] flag_pipe;
		logic tx_irq;
		logic [2:0] rx_sync;
		asr_rx_state_t rx_st;
		logic [CNT_W-1:0] rx_cnt;
		logic [3:0] rx_bits;
		logic [8:0] rx_sh;
		asr_rx_entry_t [1:0] fifo;
		logic rd_ptr;
		logic [1:0] count;
		logic ovr;
		logic rx_irq;
	} asr_state_t;

endpackage

// file: asr_node.sv
`timescale 1ns/1ns
module asr_node #(
	parameter int BT = 8
) (
	// clock
	input wire logic hclk,
	// serial lines
	output logic rx_line,
	input wire logic tx_line
);
	initial rx_line = 1'b1;
	// start edge from an idle-high line
	task automatic send(input logic [8:0] d, input int n);
		rx_line <= 1'b0;
		repeat (BT) @(posedge hclk);
		for (int i = 0; i < n; i++) begin
			rx_line <= d[i];
			repeat (BT) @(posedge hclk);
		end
		rx_line <= 1'b1;
		repeat (BT) @(posedge hclk);
	endtask
	// samples mid-bit, so a one-cycle skew of the sender is tolerated
	task automatic recv(input int n, output logic [8:0] d, output logic stop);
		d = '0;
		while (tx_line !== 1'b0) @(posedge hclk);
		repeat (BT / 2) @(posedge hclk);
		for (int i = 0; i < n; i++) begin
			repeat (BT) @(posedge hclk);
			d[i] = tx_line;
		end
		repeat (BT) @(posedge hclk);
		stop = tx_line;
	endtask
endmodule // asr_node

// file: asr_top_tb_top.sv
`timescale 1ns/1ns
module asr_top_tb_top;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic rx_pin, tx_pin, tx_int_req, rx_int_req, s0, s1;
	logic [8:0] d0, d1;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;

	asr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .tx_int_req(tx_int_req),
		.rx_int_req(rx_int_req));
	asr_node #(.BT(8)) node (.hclk(hclk), .rx_line(rx_pin), .tx_line(tx_pin));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		check(hresp, 1'b0);
		// idle cycle: a read may not sit in a write's data phase
		@(posedge hclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0000_0000, r);
		check(r & m, e);
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(asr_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk(asr_pkg::OFS_IEN, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
		// 8 cycles a bit: divisor 1, wide and high speed
		wr(asr_pkg::OFS_BAUD, 32'h0000_0001);
		wr(asr_pkg::OFS_CTRL, 32'h0000_00E5);
		wr(asr_pkg::OFS_IEN, 32'h0000_000F);
		rd_chk(asr_pkg::OFS_BAUD, 32'hFFFF_FFFF, 32'h0000_0001);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_003F, 32'h0000_0001);
		check(tx_int_req, 1'b1);
		wr(asr_pkg::OFS_STAT, 32'h0000_0000);
		wr(asr_pkg::OFS_IEN, 32'h0000_000E);
		// request is registered one cycle after the enable lands
		@(posedge hclk);
		check(tx_int_req, 1'b0);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_0001, 32'h0000_0001);
		wr(asr_pkg::OFS_IEN, 32'h0000_000F);
		fork
			begin
				node.recv(8, d0, s0);
				node.recv(8, d1, s1);
			end
			begin
				wr(asr_pkg::OFS_TXBUF, 32'h0000_00A5);
				wr(asr_pkg::OFS_TXBUF, 32'h0000_013C);
				wr(asr_pkg::OFS_STAT, 32'h0000_0001);
				wr(asr_pkg::OFS_IEN, 32'h0000_000E);
				repeat (asr_pkg::TXFLAG_DELAY) @(posedge hclk);
				rd_chk(asr_pkg::OFS_STAT, 32'h0000_0021, 32'h0000_0020);
				check(tx_int_req, 1'b0);
			end
		join
		check({23'h00_0000, d0}, 32'h0000_00A5);
		check({23'h00_0000, d1}, 32'h0000_003C);
		check({s0, s1}, 2'b11);
		// recv returns mid stop bit; let the shifter finish it
		repeat (8) @(posedge hclk);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_0021, 32'h0000_0001);
		wr(asr_pkg::OFS_IEN, 32'h0000_000F);
		node.send(9'h05A, 8);
		repeat (4) @(posedge hclk);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_001E, 32'h0000_0002);
		check(rx_int_req, 1'b1);
		wr(asr_pkg::OFS_IEN, 32'h0000_0007);
		@(posedge hclk);
		check(rx_int_req, 1'b0);
		wr(asr_pkg::OFS_IEN, 32'h0000_000F);
		rd_chk(asr_pkg::OFS_RXBUF, 32'hFFFF_FFFF, 32'h0000_005A);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_0002, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			node.send(9'h010 + 9'(i), 8);
		end
		repeat (4) @(posedge hclk);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_0006, 32'h0000_0006);
		rd_chk(asr_pkg::OFS_RXBUF, 32'hFFFF_FFFF, 32'h0000_0010);
		rd_chk(asr_pkg::OFS_RXBUF, 32'hFFFF_FFFF, 32'h0000_0011);
		wr(asr_pkg::OFS_CTRL, 32'h0000_00E1);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_0004, 32'h0000_0000);
		wr(asr_pkg::OFS_CTRL, 32'h0000_00FD);
		node.send(9'h012, 9);
		node.send(9'h1C3, 9);
		repeat (4) @(posedge hclk);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_001E, 32'h0000_0012);
		rd_chk(asr_pkg::OFS_RXBUF, 32'hFFFF_FFFF, 32'h0000_00C3);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_0002, 32'h0000_0000);
		wr(asr_pkg::OFS_CTRL, 32'h0000_00ED);
		node.send(9'h034, 9);
		repeat (4) @(posedge hclk);
		rd_chk(asr_pkg::OFS_STAT, 32'h0000_001E, 32'h0000_0002);
		rd_chk(asr_pkg::OFS_RXBUF, 32'hFFFF_FFFF, 32'h0000_0034);
		report_and_stop();
	end
endmodule // asr_top_tb_top
